/* core/dcmp_defs.svh */
`ifndef DCMP_DEFS_SVH
`define DCMP_DEFS_SVH

// register indices; byte address is four times the index
`define DCMP_IDX_CELL_AUX  12'h33A
`define DCMP_IDX_PIN_OW    12'h33B
`define DCMP_IDX_IRQ_STAT  12'h340
`define DCMP_IDX_IRQ_CLR   12'h341
`define DCMP_IDX_IRQ_EN    12'h342

// reset values
`define DCMP_CELL_AUX_RST  5'h00
`define DCMP_PIN_OW_RST    7'h00
`define DCMP_IRQ_RST       5'h00

// field positions and widths
`define DCMP_CA_LSB        0
`define DCMP_CA_W          5
`define DCMP_OW_LSB        0
`define DCMP_OW_W          4
`define DCMP_PIN_LSB       4
`define DCMP_PIN_W         3
`define DCMP_NUM_CHECKS    5

// limit ranges in mV: base at code zero, step per code
`define DCMP_CA_BASE_MV    16'h0006
`define DCMP_CA_STEP_MV    16'h0003
`define DCMP_PIN_BASE_MV   16'h0004
`define DCMP_PIN_STEP_MV   16'h0004
`define DCMP_OW_BASE_MV    16'h01F4
`define DCMP_OW_STEP_MV    16'h012C

`endif

/* core/dcmp_pkg.sv */
package dcmp_pkg;

   // kind of comparison requested by the diagnostic sequencer
   typedef enum logic [2:0] {
      dcmp_cell_aux,
      dcmp_busbar,
      dcmp_aux_pin,
      dcmp_ow_balance,
      dcmp_ow_cell
   } dcmp_kind_e;

   typedef struct packed {
      logic        valid;
      dcmp_kind_e  kind;
      logic [15:0] main_mv;
      logic [15:0] aux_mv;
   } dcmp_req_s;

   typedef struct packed {
      logic        valid;
      dcmp_kind_e  kind;
      logic        pass;
      logic [15:0] delta_mv;
   } dcmp_res_s;

   typedef struct packed {
      logic [15:0] cell_aux_mv;
      logic [15:0] aux_pin_mv;
      logic [15:0] open_wire_mv;
   } dcmp_limits_s;

endpackage

/* core/dcmp_limit_decode.sv */
`timescale 1ns/1ps
`include "dcmp_defs.svh"

module dcmp_limit_decode
   import dcmp_pkg::*;
(
   input  wire logic [`DCMP_CA_W-1:0]  cell_aux_delta_limit,
   input  wire logic [`DCMP_PIN_W-1:0] aux_pin_delta_limit,
   input  wire logic [`DCMP_OW_W-1:0]  open_wire_limit,
   output dcmp_limits_s                limits
);

   // linear map: code zero is the base, each code adds one step
   function automatic logic [15:0] lin_limit(input logic [15:0] base,
                                             input logic [15:0] step,
                                             input logic [4:0]  code);
      logic [20:0] prod;
      prod = step * code;
      return 16'(base + prod[15:0]);
   endfunction

   // three independent codes decoded to millivolts
   always_comb begin
      limits.cell_aux_mv  = lin_limit(`DCMP_CA_BASE_MV, `DCMP_CA_STEP_MV,
                                      cell_aux_delta_limit);
      limits.aux_pin_mv   = lin_limit(`DCMP_PIN_BASE_MV, `DCMP_PIN_STEP_MV,
                                      {2'h0, aux_pin_delta_limit});
      limits.open_wire_mv = lin_limit(`DCMP_OW_BASE_MV, `DCMP_OW_STEP_MV,
                                      {1'h0, open_wire_limit});
   end

endmodule

/* core/dcmp_diag_compare.sv */
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dcmp_defs.svh"

module dcmp_diag_compare
   import dcmp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  dcmp_req_s        req,
   output dcmp_res_s        res,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // bus address and data phase

   logic                          dph_write_reg;
   logic                          dph_hit_reg;
   logic [11:0]                   dph_idx_reg;
   logic                          aph_take;
   logic [`DCMP_CA_W-1:0]         cell_aux_reg;
   logic [`DCMP_CA_W-1:0]         cell_aux_next;
   logic [6:0]                    pin_ow_reg;
   logic [6:0]                    pin_ow_next;
   logic [`DCMP_NUM_CHECKS-1:0]   stat_reg;
   logic [`DCMP_NUM_CHECKS-1:0]   stat_next;
   logic [`DCMP_NUM_CHECKS-1:0]   en_reg;
   logic [`DCMP_NUM_CHECKS-1:0]   en_next;
   logic [`DCMP_NUM_CHECKS-1:0]   clr_mask;
   logic [`DCMP_NUM_CHECKS-1:0]   fail_set;
   logic [31:0]                   hrdata_reg;
   logic                          wr_now;
   dcmp_limits_s                  limits;

   // only word-aligned addresses inside the small window decode
   function automatic logic addr_hit(input logic [31:0] a);
      return (a[31:14] == 18'h00000) && (a[1:0] == 2'h0);
   endfunction

   assign aph_take  = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;   // zero wait states on every access
   assign hresp     = 1'b0;   // always OKAY, unmapped included
   assign wr_now    = dph_hit_reg && dph_write_reg;
   assign hrdata    = hrdata_reg;

   // address phase capture; hsize is ignored since only words are used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_write_reg <= 1'b0;
         dph_hit_reg   <= 1'b0;
         dph_idx_reg   <= 12'h000;
      end else if (hready) begin
         dph_write_reg <= aph_take && hwrite;
         dph_hit_reg   <= aph_take && addr_hit(haddr);
         dph_idx_reg   <= haddr[13:2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // threshold registers

   // write lands at the end of the data phase; reserved bit never stored
   always_comb begin
      cell_aux_next = cell_aux_reg;
      pin_ow_next   = pin_ow_reg;
      en_next       = en_reg;
      clr_mask      = '0;
      if (wr_now) begin
         unique case (dph_idx_reg)
            `DCMP_IDX_CELL_AUX: cell_aux_next = hwdata[`DCMP_CA_W-1:0];
            `DCMP_IDX_PIN_OW:   pin_ow_next   = hwdata[6:0];
            `DCMP_IDX_IRQ_EN:   en_next       = hwdata[`DCMP_NUM_CHECKS-1:0];
            `DCMP_IDX_IRQ_CLR:  clr_mask      = hwdata[`DCMP_NUM_CHECKS-1:0];
            default: ;
         endcase
      end
   end

   // both limit registers come out of reset at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cell_aux_reg <= `DCMP_CELL_AUX_RST;
         pin_ow_reg   <= `DCMP_PIN_OW_RST;
      end else begin
         cell_aux_reg <= cell_aux_next;
         pin_ow_reg   <= pin_ow_next;
      end
   end

   // read data from next values so a read right after a write sees it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h00000000;
      end else if (aph_take && !hwrite) begin
         hrdata_reg <= 32'h00000000;
         if (addr_hit(haddr)) begin
            unique case (haddr[13:2])
               `DCMP_IDX_CELL_AUX: hrdata_reg <= {27'h0000000, cell_aux_next};
               `DCMP_IDX_PIN_OW:   hrdata_reg <= {25'h0000000, pin_ow_next};
               `DCMP_IDX_IRQ_STAT: hrdata_reg <= {27'h0000000, stat_next};
               `DCMP_IDX_IRQ_EN:   hrdata_reg <= {27'h0000000, en_next};
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparison

   dcmp_limit_decode dcmp_limit_decode_i (
      .cell_aux_delta_limit (cell_aux_reg),
      .aux_pin_delta_limit  (pin_ow_reg[`DCMP_PIN_LSB +: `DCMP_PIN_W]),
      .open_wire_limit      (pin_ow_reg[`DCMP_OW_LSB +: `DCMP_OW_W]),
      .limits               (limits)
   );

   logic [15:0] req_delta;
   logic [15:0] req_limit;

   // magnitude of main minus aux, then the limit that governs this kind
   always_comb begin
      req_delta = (req.main_mv >= req.aux_mv) ? 16'(req.main_mv - req.aux_mv)
                                               : 16'(req.aux_mv - req.main_mv);
      unique case (req.kind)
         dcmp_cell_aux, dcmp_busbar:    req_limit = limits.cell_aux_mv;
         dcmp_aux_pin:                  req_limit = limits.aux_pin_mv;
         dcmp_ow_balance, dcmp_ow_cell: req_limit = limits.open_wire_mv;
         default:                       req_limit = 16'h0000;
      endcase
   end

   // one cycle from request to result; pass only strictly below
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res <= '0;
      end else begin
         res.valid    <= req.valid;
         res.kind     <= req.kind;
         res.pass     <= req_delta < req_limit;
         res.delta_mv <= req_delta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status

   always_comb begin
      fail_set = '0;
      if (res.valid && !res.pass) begin
         fail_set[res.kind] = 1'b1;
      end
   end

   // set wins over a clear in the same cycle so no failure is lost
   assign stat_next = (stat_reg & ~clr_mask) | fail_set;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_reg <= `DCMP_IRQ_RST;
         en_reg   <= `DCMP_IRQ_RST;
      end else begin
         stat_reg <= stat_next;
         en_reg   <= en_next;
      end
   end

   assign irq = |(stat_reg & en_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // independent reference of the linear maps
   int exp_ca;
   int exp_pin;
   int exp_ow;
   assign exp_ca  = 6 + 3 * int'(cell_aux_reg);
   assign exp_pin = 4 + 4 * int'(pin_ow_reg[6:4]);
   assign exp_ow  = 500 + 300 * int'(pin_ow_reg[3:0]);

   sequence s_wr(logic [11:0] idx);
      dph_hit_reg && dph_write_reg && (dph_idx_reg == idx);
   endsequence

   sequence s_req(dcmp_kind_e k);
      req.valid && (req.kind == k);
   endsequence

   // limit is captured at the request edge, the value the verdict must use
   property p_verdict(dcmp_kind_e k, int lim);
      int lim_v;
      (s_req(k), lim_v = lim) |=>
         res.valid && (res.pass == (int'(res.delta_mv) < lim_v));
   endproperty

   cell_limit_write_a: assert property (s_wr(`DCMP_IDX_CELL_AUX) |=>
         cell_aux_reg == $past(hwdata[4:0]))
      else $error("cell limit write not stored");
   cell_verdict_a: assert property (p_verdict(dcmp_cell_aux, exp_ca))
      else $error("cell compare verdict wrong");
   busbar_verdict_a: assert property (p_verdict(dcmp_busbar, exp_ca))
      else $error("busbar compare verdict wrong");
   pin_verdict_a: assert property (p_verdict(dcmp_aux_pin, exp_pin))
      else $error("pin compare verdict wrong");
   ow_range_a: assert property (exp_ow >= 500 && exp_ow <= 5000 &&
         int'(limits.open_wire_mv) == exp_ow)
      else $error("open wire limit off range");
   ow_balance_a: assert property (p_verdict(dcmp_ow_balance, exp_ow))
      else $error("balance open wire verdict wrong");
   ow_cell_a: assert property (p_verdict(dcmp_ow_cell, exp_ow))
      else $error("cell input open wire verdict wrong");
   reserved_read_a: assert property (aph_take && !hwrite &&
         haddr == {18'h00000, `DCMP_IDX_PIN_OW, 2'h0} |=> hrdata[31:7] == 25'h0)
      else $error("reserved bits read nonzero");
   fail_sticky_a: assert property (res.valid && !res.pass |=>
         stat_reg[$past(res.kind)] ##1 stat_reg[$past(res.kind, 2)] || $past(wr_now))
      else $error("failure flag not set");

endmodule

/* verif/tb_dcmp_diag_compare.sv */
`timescale 1ns/1ps
`include "dcmp_defs.svh"

module tb_dcmp_diag_compare
   import dcmp_pkg::*;
;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire         hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   dcmp_req_s   req;
   dcmp_res_s   res;
   logic        irq;
   int          fails;
   int          n_compared;
   int          cyc = 0;
   logic [4:0]  cas [3] = '{5'h00, 5'h1F, 5'h05};
   logic [2:0]  pns [3] = '{3'h0, 3'h7, 3'h3};
   logic [3:0]  ows [3] = '{4'h0, 4'hF, 4'h6};

   // one slave, so its ready is the bus ready
   assign hready = hreadyout;

   dcmp_diag_compare dcmp_diag_compare_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req), .res(res),
      .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard; whole run is well under a thousand cycles
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] ba(input logic [11:0] idx);
      return {18'h00000, idx, 2'b00};
   endfunction

   // limit in mV worked out from each range: minimum plus one step per code
   function automatic logic [15:0] lim(input int k, input logic [4:0] ca,
                                       input logic [2:0] pn, input logic [3:0] ow);
      if (k < 2) return 16'h0006 + 16'h0003 * ca;
      if (k == 2) return 16'h0004 + 16'h0004 * pn;
      return 16'h01F4 + 16'h012C * ow;
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one single AHB-Lite transfer; waits on ready in both phases
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, x);
      chk(nm, x, exp);
      chk("bus resp", {30'h0, hreadyout, hresp}, 32'h00000002);
   endtask

   // passing request then failing one, back to back, both sides of the limit
   task automatic pair(input int k, input logic [15:0] l);
      @(posedge hclk);
      req <= '{valid: 1'b1, kind: dcmp_kind_e'(k), main_mv: 16'h0064,
               aux_mv: 16'h0064 + l - 16'h0001};
      @(posedge hclk);
      req <= '{valid: 1'b1, kind: dcmp_kind_e'(k), main_mv: 16'h0064 + l,
               aux_mv: 16'h0064};
      #1;
      chk("res pass lo", {res.valid, res.pass, res.delta_mv}, {2'b11, l - 16'h0001});
      @(posedge hclk);
      req.valid <= 1'b0;
      #1;
      chk("res pass hi", {res.valid, res.pass, res.delta_mv}, {2'b10, l});
      chk("res kind", {29'h0, res.kind}, k);
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      req = '0;
      fails = 0;
      n_compared = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("cell_aux rst", ba(`DCMP_IDX_CELL_AUX), 32'h00000000);
      rdchk("pin_ow rst", ba(`DCMP_IDX_PIN_OW), 32'h00000000);
      rdchk("status rst", ba(`DCMP_IDX_IRQ_STAT), 32'h00000000);
      rdchk("enable rst", ba(`DCMP_IDX_IRQ_EN), 32'h00000000);
      wr(ba(`DCMP_IDX_CELL_AUX), 32'hFFFFFFFF);
      wr(ba(`DCMP_IDX_PIN_OW), 32'hFFFFFFFF);
      rdchk("cell_aux wide", ba(`DCMP_IDX_CELL_AUX), 32'h0000001F);
      rdchk("pin_ow wide", ba(`DCMP_IDX_PIN_OW), 32'h0000007F);
      rdchk("unmapped", 32'h00000CF0, 32'h00000000);
      $display("test registers done");
      // minimum, maximum and a middle code of every field, every kind
      for (int s = 0; s < 3; s++) begin
         wr(ba(`DCMP_IDX_CELL_AUX), {27'h0, cas[s]});
         wr(ba(`DCMP_IDX_PIN_OW), {25'h0, pns[s], ows[s]});
         for (int k = 0; k < 5; k++) begin
            pair(k, lim(k, cas[s], pns[s], ows[s]));
         end
      end
      $display("test limits done");
      // every kind failed above, so every status bit is set but none enabled
      rdchk("status all", ba(`DCMP_IDX_IRQ_STAT), 32'h0000001F);
      chk("irq masked", {31'h0, irq}, 32'h00000000);
      wr(ba(`DCMP_IDX_IRQ_EN), 32'h00000004);
      #1;
      chk("irq enabled", {31'h0, irq}, 32'h00000001);
      wr(ba(`DCMP_IDX_IRQ_CLR), 32'h00000004);
      #1;
      chk("irq cleared", {31'h0, irq}, 32'h00000000);
      rdchk("status part", ba(`DCMP_IDX_IRQ_STAT), 32'h0000001B);
      rdchk("clear reads", ba(`DCMP_IDX_IRQ_CLR), 32'h00000000);
      wr(ba(`DCMP_IDX_IRQ_EN), 32'h0000001F);
      #1;
      chk("irq other", {31'h0, irq}, 32'h00000001);
      wr(ba(`DCMP_IDX_IRQ_CLR), 32'h0000001F);
      #1;
      chk("irq none", {31'h0, irq}, 32'h00000000);
      rdchk("status none", ba(`DCMP_IDX_IRQ_STAT), 32'h00000000);
      $display("test interrupt done");
      end_sim();
   end
endmodule
